//--- rtl/rmml_bank.sv
// register bank: ring indicator mode select, dropout status, monitor output levels
// assumes ring detector and dropout pins are asynchronous; audio samples share i_clk
`timescale 1ns/10ps
module rmml_bank
	import rmml_pkg::*;
#(
	parameter int unsigned P_ONESHOT_CYCLES = ONESHOT_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_ring_half_wave,
	input wire logic i_ring_full_wave,
	input wire logic i_ring_envelope,
	input wire logic i_ring_threshold,
	input wire logic i_dropout_detect,
	input wire logic signed [15:0] i_rx_sample,
	input wire logic signed [15:0] i_tx_sample,
	output logic o_ring_indicator,
	output logic signed [15:0] o_call_progress_output,
	output logic o_irq
);
	typedef struct packed {
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic thr_prev;
		logic shot_on;
		logic [SHOT_W-1:0] shot_cnt;
		logic ring_indicator;
		logic ring_rectifier_select;
		logic ring_validation_enable;
		logic [7:0] monitor_rx_level_field;
		logic [7:0] monitor_tx_level_field;
		logic [1:0] irq_stat;
		logic [1:0] irq_en;
		logic irq;
		logic signed [15:0] cpo;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rmml_state_t;

	rmml_state_t s_r;
	rmml_state_t s_nxt;

	function automatic logic signed [24:0] rmml_scale(input logic signed [15:0] x,
		input logic [7:0] lv);
		logic signed [24:0] p;
		// widen both operands first so the product keeps all 25 bits
		p = 25'(x) * 25'(signed'({1'b0, lv}));
		return p >>> LEVEL_SHIFT;
	endfunction : rmml_scale

	function automatic logic signed [15:0] rmml_sat(input logic signed [25:0] v);
		logic signed [15:0] r;
		r = v[15:0];
		if (v > 26'sd32767) begin
			r = 16'sh7fff;
		end else if (v < -26'sd32768) begin
			r = -16'sh8000;
		end
		return r;
	endfunction : rmml_sat

	logic [7:0] idx;
	logic access;
	logic setup_done;
	logic thr_rise;
	logic [1:0] evt;
	logic [1:0] clr;
	logic mapped;
	logic [31:0] rdata;

	always_comb begin
		s_nxt = s_r;
		idx = {2'h0, i_paddr[7:2]};
		setup_done = i_psel && i_penable && !s_r.pready;
		access = i_psel && i_penable && s_r.pready;
		thr_rise = s_r.sync2[IN_THR] && !s_r.thr_prev;
		clr = 2'h0;
		mapped = 1'b1;
		rdata = 32'h0;
		// two-stage synchroniser for the detector pins
		s_nxt.sync1 = {i_dropout_detect, i_ring_threshold, i_ring_envelope,
			i_ring_full_wave, i_ring_half_wave};
		s_nxt.sync2 = s_r.sync1;
		s_nxt.thr_prev = s_r.sync2[IN_THR];
		if (s_r.shot_on) begin
			if (s_r.shot_cnt == '0) begin
				s_nxt.shot_on = 1'b0;
			end else begin
				s_nxt.shot_cnt = s_r.shot_cnt - SHOT_W'(1);
			end
		end else if (thr_rise) begin
			s_nxt.shot_on = 1'b1;
			s_nxt.shot_cnt = SHOT_W'(P_ONESHOT_CYCLES - 1);
		end
		if (!s_r.ring_validation_enable && !s_r.ring_rectifier_select) begin
			s_nxt.ring_indicator = s_r.sync2[IN_HALF];
		end else if (!s_r.ring_validation_enable) begin
			s_nxt.ring_indicator = s_r.sync2[IN_FULL];
		end else if (!s_r.ring_rectifier_select) begin
			s_nxt.ring_indicator = s_r.sync2[IN_ENV];
		end else begin
			s_nxt.ring_indicator = s_r.shot_on;
		end
		s_nxt.cpo = rmml_sat(26'(rmml_scale(i_rx_sample, s_r.monitor_rx_level_field))
			+ 26'(rmml_scale(i_tx_sample, s_r.monitor_tx_level_field)));
		// read decode; live dropout flag, no read side effect
		if (idx == REG_MODE_IDX) begin
			rdata[RECT_SEL_BIT] = s_r.ring_rectifier_select;
		end else if (idx == REG_DROP_IDX) begin
			rdata[DROP_FLAG_BIT] = s_r.sync2[IN_DROP];
		end else if (idx == REG_RXLV_IDX) begin
			rdata[7:0] = s_r.monitor_rx_level_field;
		end else if (idx == REG_TXLV_IDX) begin
			rdata[7:0] = s_r.monitor_tx_level_field;
		end else if (idx == REG_ISTAT_IDX) begin
			rdata[1:0] = s_r.irq_stat;
		end else if (idx == REG_ICLR_IDX) begin
			rdata = 32'h0;
		end else if (idx == REG_IEN_IDX) begin
			rdata[1:0] = s_r.irq_en;
		end else if (idx == REG_VCTL_IDX) begin
			rdata[VALID_EN_BIT] = s_r.ring_validation_enable;
		end else begin
			mapped = 1'b0;
		end
		// one wait state: pready rises the cycle after the first access-phase cycle
		s_nxt.pready = setup_done;
		if (setup_done) begin
			s_nxt.prdata = i_pwrite ? 32'h0 : rdata;
			s_nxt.pslverr = !mapped || (i_paddr[1:0] != 2'h0);
		end else begin
			s_nxt.pslverr = 1'b0;
		end
		// reserved bits are ignored on write
		if (access && i_pwrite && !s_r.pslverr) begin
			if (idx == REG_MODE_IDX) begin
				s_nxt.ring_rectifier_select = i_pwdata[RECT_SEL_BIT];
			end else if (idx == REG_RXLV_IDX) begin
				s_nxt.monitor_rx_level_field = i_pwdata[7:0];
			end else if (idx == REG_TXLV_IDX) begin
				s_nxt.monitor_tx_level_field = i_pwdata[7:0];
			end else if (idx == REG_ICLR_IDX) begin
				clr = i_pwdata[1:0];
			end else if (idx == REG_IEN_IDX) begin
				s_nxt.irq_en = i_pwdata[1:0];
			end else if (idx == REG_VCTL_IDX) begin
				s_nxt.ring_validation_enable = i_pwdata[VALID_EN_BIT];
			end
		end
		// sticky events, set wins over clear
		evt[IRQ_RING_BIT] = s_nxt.ring_indicator && !s_r.ring_indicator;
		evt[IRQ_DROP_BIT] = s_nxt.sync2[IN_DROP] && !s_r.sync2[IN_DROP];
		s_nxt.irq_stat = (s_r.irq_stat & ~clr) | evt;
		s_nxt.irq = |(s_r.irq_stat & s_r.irq_en);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_r <= '{sync1: 5'h0, sync2: 5'h0, thr_prev: 1'b0, shot_on: 1'b0,
				shot_cnt: '0, ring_indicator: 1'b0, ring_rectifier_select: 1'b0,
				ring_validation_enable: 1'b0, monitor_rx_level_field: LEVEL_RST,
				monitor_tx_level_field: LEVEL_RST, irq_stat: 2'h0, irq_en: 2'h0,
				irq: 1'b0, cpo: 16'sh0, prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_prdata = s_r.prdata;
	assign o_pready = s_r.pready;
	assign o_pslverr = s_r.pslverr;
	assign o_ring_indicator = s_r.ring_indicator;
	assign o_call_progress_output = s_r.cpo;
	assign o_irq = s_r.irq;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	ring_half_a: assert property (
		(!s_r.ring_validation_enable && !s_r.ring_rectifier_select)
		|=> (o_ring_indicator == $past(s_r.sync2[IN_HALF])))
		else $error("ring indicator not following half-wave detect");
	ring_full_a: assert property (
		(!s_r.ring_validation_enable && s_r.ring_rectifier_select)
		|=> (o_ring_indicator == $past(s_r.sync2[IN_FULL])))
		else $error("ring indicator not following full-wave detect");
	ring_env_a: assert property (
		(s_r.ring_validation_enable && !s_r.ring_rectifier_select)
		|=> (o_ring_indicator == $past(s_r.sync2[IN_ENV])))
		else $error("ring indicator not following validated envelope");
	shot_start_a: assert property (
		(!s_r.shot_on && s_r.sync2[IN_THR] && !s_r.thr_prev)
		|=> (s_r.shot_on && s_r.shot_cnt == SHOT_W'(P_ONESHOT_CYCLES - 1)))
		else $error("one-shot did not start on threshold crossing");
	drop_read_a: assert property (
		(i_psel && i_penable && !o_pready && !i_pwrite && i_paddr == {REG_DROP_IDX[5:0], 2'h0})
		|=> (o_pready && o_prdata[DROP_FLAG_BIT] == $past(s_r.sync2[IN_DROP])))
		else $error("dropout flag read mismatch");
	rx_unity_a: assert property (
		(s_r.monitor_rx_level_field == LEVEL_RST && s_r.monitor_tx_level_field == 8'h0)
		|=> (o_call_progress_output == $past(i_rx_sample)))
		else $error("receive path not unity at default level");
	mute_both_a: assert property (
		(s_r.monitor_rx_level_field == 8'h0 && s_r.monitor_tx_level_field == 8'h0)
		|=> (o_call_progress_output == 16'sh0))
		else $error("monitor output not muted");
	tx_unity_a: assert property (
		(s_r.monitor_tx_level_field == LEVEL_RST && s_r.monitor_rx_level_field == 8'h0)
		|=> (o_call_progress_output == $past(i_tx_sample)))
		else $error("transmit path not unity at default level");
	read_quiet_a: assert property (
		(i_psel && i_penable && o_pready && !i_pwrite)
		|=> ($stable(s_r.ring_rectifier_select) && $stable(s_r.monitor_rx_level_field)
		&& $stable(s_r.irq_en)))
		else $error("register read changed state");

	// one-shot source and its counter
	ring_shot_a: assert property (
		(s_r.ring_validation_enable && s_r.ring_rectifier_select)
		|=> (o_ring_indicator == $past(s_r.shot_on)))
		else $error("ring indicator not following one-shot");
	shot_hold_a: assert property (
		(s_r.shot_on && s_r.shot_cnt != '0)
		|=> s_r.shot_on)
		else $error("one-shot ended early");
	shot_count_a: assert property (
		(s_r.shot_on && s_r.shot_cnt != '0)
		|=> (s_r.shot_cnt == $past(s_r.shot_cnt) - SHOT_W'(1)))
		else $error("one-shot counter did not step down");
	shot_end_a: assert property (
		(s_r.shot_on && s_r.shot_cnt == '0)
		|=> !s_r.shot_on)
		else $error("one-shot did not end at timeout");
	shot_idle_a: assert property (
		(!s_r.shot_on && !(s_r.sync2[IN_THR] && !s_r.thr_prev))
		|=> !s_r.shot_on)
		else $error("one-shot started without a crossing");

	// level field and rectifier select writes, and single-path mutes
	rx_write_a: assert property (
		(i_psel && i_penable && o_pready && i_pwrite && !o_pslverr
		&& i_paddr == {REG_RXLV_IDX[5:0], 2'h0})
		|=> (s_r.monitor_rx_level_field == $past(i_pwdata[7:0])))
		else $error("receive level write lost");
	tx_write_a: assert property (
		(i_psel && i_penable && o_pready && i_pwrite && !o_pslverr
		&& i_paddr == {REG_TXLV_IDX[5:0], 2'h0})
		|=> (s_r.monitor_tx_level_field == $past(i_pwdata[7:0])))
		else $error("transmit level write lost");
	rect_write_a: assert property (
		(i_psel && i_penable && o_pready && i_pwrite && !o_pslverr
		&& i_paddr == {REG_MODE_IDX[5:0], 2'h0})
		|=> (s_r.ring_rectifier_select == $past(i_pwdata[RECT_SEL_BIT])))
		else $error("rectifier select write lost");
	rx_mute_a: assert property (
		(s_r.monitor_rx_level_field == 8'h0 && s_r.monitor_tx_level_field == LEVEL_RST)
		|=> (o_call_progress_output == $past(i_tx_sample)))
		else $error("receive path not muted at zero level");
	tx_mute_a: assert property (
		(s_r.monitor_tx_level_field == 8'h0 && s_r.monitor_rx_level_field == LEVEL_RST)
		|=> (o_call_progress_output == $past(i_rx_sample)))
		else $error("transmit path not muted at zero level");

	// bus handshake shape
	pready_pulse_a: assert property (
		o_pready |=> !o_pready)
		else $error("ready held longer than one cycle");
	setup_wait_a: assert property (
		(i_psel && !i_penable) |=> !o_pready)
		else $error("ready answered a setup cycle");
	err_with_ready_a: assert property (
		o_pslverr |-> o_pready)
		else $error("error flag without ready");
	unaligned_err_a: assert property (
		(i_psel && i_penable && !o_pready && i_paddr[1:0] != 2'h0)
		|=> o_pslverr)
		else $error("unaligned access not refused");

	// interrupt status and output
	irq_level_a: assert property (
		1'b1 |=> (o_irq == $past(|(s_r.irq_stat & s_r.irq_en))))
		else $error("interrupt output not following enabled status");
	drop_set_a: assert property (
		(s_r.sync1[IN_DROP] && !s_r.sync2[IN_DROP])
		|=> s_r.irq_stat[IRQ_DROP_BIT])
		else $error("dropout event not recorded");
	drop_sticky_a: assert property (
		(s_r.irq_stat[IRQ_DROP_BIT] && !(i_psel && i_penable && i_pwrite))
		|=> s_r.irq_stat[IRQ_DROP_BIT])
		else $error("dropout status lost without a clear");
	ring_sticky_a: assert property (
		(s_r.irq_stat[IRQ_RING_BIT] && !(i_psel && i_penable && i_pwrite))
		|=> s_r.irq_stat[IRQ_RING_BIT])
		else $error("ring status lost without a clear");
endmodule : rmml_bank

//--- rtl/rmml_pkg.sv
// constants for the ring mode and call-progress monitor level register bank
// assumes an apb master on the same 50 MHz clock as the block
package rmml_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] REG_MODE_IDX = 8'h12;
	localparam logic [7:0] REG_DROP_IDX = 8'h13;
	localparam logic [7:0] REG_RXLV_IDX = 8'h14;
	localparam logic [7:0] REG_TXLV_IDX = 8'h15;
	localparam logic [7:0] REG_ISTAT_IDX = 8'h16;
	localparam logic [7:0] REG_ICLR_IDX = 8'h17;
	localparam logic [7:0] REG_IEN_IDX = 8'h18;
	localparam logic [7:0] REG_VCTL_IDX = 8'h19;
	// field positions
	localparam int RECT_SEL_BIT = 1;
	localparam int DROP_FLAG_BIT = 1;
	localparam int VALID_EN_BIT = 0;
	localparam int IRQ_RING_BIT = 0;
	localparam int IRQ_DROP_BIT = 1;
	// synchronised input positions
	localparam int IN_HALF = 0;
	localparam int IN_FULL = 1;
	localparam int IN_ENV = 2;
	localparam int IN_THR = 3;
	localparam int IN_DROP = 4;
	// reset values and level scaling
	localparam logic [7:0] LEVEL_RST = 8'h40;
	localparam logic LEVEL_UNITY_SHIFT_DUMMY = 1'b0;
	localparam int LEVEL_SHIFT = 6;
	// one-shot timing
	localparam longint CLK_PERIOD_NS = 20;
	localparam longint ONESHOT_TIME_MS = 5000;
	localparam longint ONESHOT_CYCLES_L = ONESHOT_TIME_MS * 64'd1000000 / CLK_PERIOD_NS;
	localparam int unsigned ONESHOT_CYCLES = int'(ONESHOT_CYCLES_L);
	localparam int SHOT_W = 28;
endpackage : rmml_pkg

//--- verification/rmml_line_model.sv
// line-side model: ring detector, dropout pin and audio samples feeding the bank
// assumes the bench sets the wanted pin pattern and samples; all change after a rising edge
`timescale 1ns/10ps
module rmml_line_model (
	input wire logic i_clk,
	input wire logic [4:0] i_pins,
	input wire logic signed [15:0] i_rx,
	input wire logic signed [15:0] i_tx,
	output logic [4:0] o_pins,
	output logic signed [15:0] o_rx,
	output logic signed [15:0] o_tx
);
	always @(posedge i_clk) begin
		o_pins <= i_pins;
		o_rx <= i_rx;
		o_tx <= i_tx;
	end
endmodule : rmml_line_model

//--- verification/ring_mode_and_monitor_levels_bench.sv
// bench for the ring mode and monitor level bank, driven over apb
// assumes one 50 MHz clock and a shortened one-shot of 20 cycles
`timescale 1ns/10ps
module ring_mode_and_monitor_levels_bench;
	import rmml_pkg::*;
	logic i_clk = 0, i_sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, ring, irq, err;
	logic [4:0] pins = 5'h00, lp;
	logic signed [15:0] rx = 0, tx = 0, lrx, ltx, cpo;
	int miscompares = 0, compares = 0;
	always #10 i_clk = ~i_clk;
	rmml_line_model rmml_line_model_inst (.i_clk(i_clk), .i_pins(pins), .i_rx(rx), .i_tx(tx),
		.o_pins(lp), .o_rx(lrx), .o_tx(ltx));
	rmml_bank #(.P_ONESHOT_CYCLES(20)) rmml_bank_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_ring_half_wave(lp[IN_HALF]), .i_ring_full_wave(lp[IN_FULL]),
		.i_ring_envelope(lp[IN_ENV]), .i_ring_threshold(lp[IN_THR]),
		.i_dropout_detect(lp[IN_DROP]), .i_rx_sample(lrx), .i_tx_sample(ltx),
		.o_ring_indicator(ring), .o_call_progress_output(cpo), .o_irq(irq));
	task close_out;
		$display("counts: %0d compares, %0d miscompares", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= wd;
		@(posedge i_clk);
		penable <= 1'b1;
		@(posedge i_clk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge i_clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			miscompares++;
			close_out();
		end
		@(posedge i_clk);
	endtask : apb
	task wait_chk(input int n, input logic [31:0] seen_sel, input logic [31:0] exp);
		repeat (n) @(posedge i_clk);
		#1;
		chk(seen_sel == 0 ? {31'h0, ring} : seen_sel == 1 ? {31'h0, irq} : 32'(cpo), exp, "port");
	endtask : wait_chk
	task lvl(input logic [7:0] idx, input logic [7:0] v, input logic [31:0] exp);
		apb(1, idx, {24'h0, v});
		wait_chk(4, 2, exp);
	endtask : lvl
	initial begin
		repeat (12) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		apb(0, REG_RXLV_IDX, 0); chk(rd, 32'h40, "rx level reset");
		apb(0, REG_TXLV_IDX, 0); chk(rd, 32'h40, "tx level reset");
		for (int m = 0; m < 3; m++) begin
			// reserved bits written as zero
			apb(1, REG_VCTL_IDX, {31'h0, m[1]});
			apb(1, REG_MODE_IDX, {30'h0, m[0], 1'b0});
			pins <= 5'(1 << m);
			wait_chk(5, 0, 1);
			pins <= 5'h0f & ~5'(1 << m);
			wait_chk(5, 0, 0);
		end
		pins <= 5'h00;
		apb(1, REG_MODE_IDX, 32'h2);
		pins <= 5'h08;
		wait_chk(5, 0, 1);
		wait_chk(30, 0, 0);
		pins <= 5'h00;
		$display("test ring modes done");
		apb(1, REG_ICLR_IDX, 32'h3);
		apb(1, REG_IEN_IDX, 32'h2);
		wait_chk(1, 1, 0);
		pins <= 5'h10;
		wait_chk(5, 1, 1);
		apb(0, REG_DROP_IDX, 0); chk(rd, 32'h2, "dropout set");
		apb(0, REG_DROP_IDX, 0); chk(rd, 32'h2, "dropout reread");
		apb(0, REG_ISTAT_IDX, 0); chk(rd, 32'h2, "irq status");
		apb(1, REG_IEN_IDX, 32'h0);
		wait_chk(2, 1, 0);
		apb(1, REG_IEN_IDX, 32'h2);
		apb(1, REG_ICLR_IDX, 32'h2);
		wait_chk(2, 1, 0);
		pins <= 5'h00;
		wait_chk(5, 1, 0);
		apb(0, REG_DROP_IDX, 0); chk(rd, 32'h0, "dropout clear");
		apb(0, 8'h30, 0); chk({31'h0, err}, 1, "unmapped err");
		$display("test dropout and irq done");
		rx <= 16'sd1000;
		lvl(REG_RXLV_IDX, 8'h7f, 32'(16'sd1984));
		lvl(REG_RXLV_IDX, 8'h20, 32'(16'sd500));
		lvl(REG_RXLV_IDX, 8'h00, 32'h0);
		tx <= 16'sd800;
		lvl(REG_TXLV_IDX, 8'h10, 32'(16'sd200));
		lvl(REG_TXLV_IDX, 8'h40, 32'(16'sd800));
		lvl(REG_TXLV_IDX, 8'h00, 32'h0);
		$display("test monitor levels done");
		close_out();
	end
endmodule : ring_mode_and_monitor_levels_bench
